// >>> smb_ctrl.sv
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
module smb_ctrl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Bus clock pin, open drain
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	// Bus data pin, open drain
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n
);
	// Control and status state
	logic master, transmit_direction_flag, start_request, sto, ack_request_flag, arbitration_lost_flag, ack, si;
	logic [7:0] data; // Shift and data register
	logic dat_wr; // Data written since the last byte began
	logic [7:0] saddr, smask; // Own address and compare mask
	logic [2:0] cfg; // Enable, inhibit, hardware ack
	// Engine state
	smb_pkg::phase_e phase;
	logic [1:0] step; // Sub-step of start and stop sequences
	logic [3:0] bit_cnt; // Bit slot within the frame
	logic is_addr; // Current frame is a slave address
	logic ack_out; // Latched hardware ack decision
	logic far_ack; // Far end's answer; software writes cannot touch it
	logic ignore; // Address refused; slave flags muted
	logic bus_busy; // Between START and STOP on the wire
	logic si_d; // Delayed flag gives data setup on release
	logic mscl_low, sda_low, scl_drv;
	logic [10:0] div_cnt;
	logic tick;
	// Pin synchronisers
	logic scl_q1, scl_q2, scl_q3, sda_q1, sda_q2, sda_q3;
	logic rise_ev, fall_ev, start_det, stop_det;
	logic hw, acked, byte_end, do_next;
	logic wr_ctrl, wr_data, access;

	// Address decode for the error answer; the read mux decodes on its own
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == smb_pkg::ADDR_CTRL) || (a == smb_pkg::ADDR_DATA) ||
			(a == smb_pkg::ADDR_SADDR) || (a == smb_pkg::ADDR_SMASK) ||
			(a == smb_pkg::ADDR_CFG);
	endfunction : mapped

	// Masked compare of the received seven address bits
	function automatic logic addr_hit(input logic [7:0] rx,
		input logic [7:0] own, input logic [7:0] msk);
		addr_hit = (((rx ^ own) & msk) & 8'hFE) == 8'h00;
	endfunction : addr_hit

	// Bus strobes; zero wait states, so access completes at once
	assign access = psel && penable;
	assign pready = 1'b1;
	assign pslverr = access && !mapped(paddr);
	assign wr_ctrl = access && pwrite && (paddr == smb_pkg::ADDR_CTRL);
	assign wr_data = access && pwrite && (paddr == smb_pkg::ADDR_DATA);

	// Open drain pins only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = !scl_drv;
	assign sda_oe_n = !sda_low;

	// Wire events seen through the synchronisers
	assign rise_ev = scl_q2 && !scl_q3;
	assign fall_ev = !scl_q2 && scl_q3;
	assign start_det = scl_q2 && scl_q3 && !sda_q2 && sda_q3;
	assign stop_det = scl_q2 && scl_q3 && sda_q2 && !sda_q3;

	assign hw = cfg[smb_pkg::CFG_HWACK];
	// Effective ack of a received frame
	assign acked = hw ? ack_out : ack;
	assign byte_end = (phase == smb_pkg::PH_BYTE) && fall_ev &&
		(bit_cnt == smb_pkg::ACK_SLOT);
	// Next frame decision: direct after a pre-ack flag, else on release.
	// Taken one cycle before the clock lets go, so new data has setup.
	assign do_next = (byte_end && !transmit_direction_flag && !hw &&
		!(is_addr && !master && !acked)) ||
		((phase == smb_pkg::PH_WAIT) && !si && si_d);

	// Two flops before any logic looks at the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{scl_q1, scl_q2, scl_q3} <= 3'h7;
			{sda_q1, sda_q2, sda_q3} <= 3'h7;
		end else begin
			{scl_q3, scl_q2, scl_q1} <= {scl_q2, scl_q1, scl_in};
			{sda_q3, sda_q2, sda_q1} <= {sda_q2, sda_q1, sda_in};
		end
	end

	// Half period divider for the generated clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 11'h000;
			tick <= 1'b0;
		end else if (div_cnt == 11'(smb_pkg::SCL_HALF_CYC - 1)) begin
			div_cnt <= 11'h000;
			tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 11'h001;
			tick <= 1'b0;
		end
	end

	// Configuration, own address and mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saddr <= smb_pkg::SADDR_RST;
			smask <= smb_pkg::SMASK_RST;
			cfg <= smb_pkg::CFG_RST;
		end else if (access && pwrite) begin
			if (paddr == smb_pkg::ADDR_SADDR)
				saddr <= pwdata[7:0];
			if (paddr == smb_pkg::ADDR_SMASK)
				smask <= pwdata[7:0];
			if (paddr == smb_pkg::ADDR_CFG)
				cfg <= pwdata[2:0];
		end
	end

	// Read data captured in the setup cycle, valid in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (paddr)
				smb_pkg::ADDR_CTRL: prdata <= {24'h000000, master, transmit_direction_flag,
					start_request, sto, ack_request_flag, arbitration_lost_flag, ack, si};
				smb_pkg::ADDR_DATA: prdata <= {24'h000000, data};
				smb_pkg::ADDR_SADDR: prdata <= {24'h000000, saddr};
				smb_pkg::ADDR_SMASK: prdata <= {24'h000000, smask};
				smb_pkg::ADDR_CFG: prdata <= {29'h0000000, cfg};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Clock hold: keep the line low once it is low and the flag is up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			si_d <= 1'b0;
			scl_drv <= 1'b0;
		end else begin
			si_d <= si;
			scl_drv <= mscl_low ||
				((si || si_d) && (!scl_q2 || scl_drv));
		end
	end

	// Byte engine, status bits and data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{master, transmit_direction_flag, start_request, sto} <= 4'h0;
			{ack_request_flag, arbitration_lost_flag, ack, si} <= 4'h0;
			data <= 8'h00;
			dat_wr <= 1'b0;
			phase <= smb_pkg::PH_IDLE;
			step <= 2'h0;
			bit_cnt <= 4'h0;
			is_addr <= 1'b0;
			ack_out <= 1'b0;
			far_ack <= 1'b0;
			ignore <= 1'b0;
			bus_busy <= 1'b0;
			mscl_low <= 1'b0;
			sda_low <= 1'b0;
		end else begin
			// Software writes; hardware sets below win over clears
			if (wr_ctrl) begin
				start_request <= pwdata[smb_pkg::CS_STA];
				sto <= pwdata[smb_pkg::CS_STO];
				ack <= pwdata[smb_pkg::CS_ACK];
				if (!pwdata[smb_pkg::CS_SI])
					si <= 1'b0;
				if (!pwdata[smb_pkg::CS_ARB])
					arbitration_lost_flag <= 1'b0;
			end
			// Software should only do this while the flag is up
			if (wr_data) begin
				data <= pwdata[7:0];
				dat_wr <= 1'b1;
			end
			case (phase)
				// Wait for a start request on a free bus
				smb_pkg::PH_IDLE: begin
					if (cfg[smb_pkg::CFG_EN] && start_request && !bus_busy) begin
						phase <= smb_pkg::PH_START;
						step <= 2'h1;
					end
				end
				// Start or repeated start, one step per half period
				smb_pkg::PH_START: begin
					if (tick) begin
						case (step)
							2'h0: begin
								sda_low <= 1'b0;
								mscl_low <= 1'b1;
								step <= 2'h1;
							end
							2'h1: begin
								mscl_low <= 1'b0;
								step <= 2'h2;
							end
							2'h2: begin
								// Stretched clock: wait for it high
								if (scl_q2) begin
									sda_low <= 1'b1;
									master <= 1'b1;
									step <= 2'h3;
								end
							end
							default: begin
								mscl_low <= 1'b1;
								transmit_direction_flag <= 1'b1;
								si <= 1'b1;
								phase <= smb_pkg::PH_WAIT;
							end
						endcase
					end
				end
				// Stop, then start again if still requested
				smb_pkg::PH_STOP: begin
					if (tick) begin
						case (step)
							2'h0: begin
								sda_low <= 1'b1;
								step <= 2'h1;
							end
							2'h1: begin
								mscl_low <= 1'b0;
								step <= 2'h2;
							end
							2'h2: begin
								if (scl_q2) begin
									sda_low <= 1'b0;
									step <= 2'h3;
								end
							end
							default: begin
								master <= 1'b0;
								transmit_direction_flag <= 1'b0;
								sto <= 1'b0;
								if (start_request) begin
									phase <= smb_pkg::PH_START;
									step <= 2'h1;
								end else begin
									phase <= smb_pkg::PH_IDLE;
								end
							end
						endcase
					end
				end
				// Shift one frame of eight bits and the ack slot
				smb_pkg::PH_BYTE: begin
					// Master clock; paused while the flag holds it
					if (master && tick && !si && !si_d) begin
						if (scl_q2)
							mscl_low <= 1'b1;
						else if (mscl_low)
							mscl_low <= 1'b0;
					end
					// Receiver drives its ack while the clock is low
					if (bit_cnt == smb_pkg::ACK_SLOT && !transmit_direction_flag && !scl_q2)
						sda_low <= acked;
					if (rise_ev) begin
						if (bit_cnt != smb_pkg::ACK_SLOT)
							data <= {data[6:0], sda_q2};
						// Transmitter takes the far end's ack
						if (bit_cnt == smb_pkg::ACK_SLOT && transmit_direction_flag) begin
							ack <= !sda_q2;
							far_ack <= !sda_q2;
						end
						// Lost a released bit to another master
						if (master && transmit_direction_flag && !sda_low && !sda_q2 &&
							bit_cnt != smb_pkg::ACK_SLOT) begin
							arbitration_lost_flag <= 1'b1;
							master <= 1'b0;
							mscl_low <= 1'b0;
							si <= 1'b1;
							phase <= smb_pkg::PH_SKIP;
						end
						if (bit_cnt == smb_pkg::LAST_BIT && !transmit_direction_flag) begin
							ack_out <= is_addr ?
								addr_hit({data[6:0], sda_q2}, saddr, smask) :
								ack;
							if (!hw) begin
								si <= 1'b1;
								ack_request_flag <= 1'b1;
							end
							if (is_addr && !master && (!hw ||
								addr_hit({data[6:0], sda_q2}, saddr, smask)))
								start_request <= 1'b1;
						end
					end
					if (fall_ev) begin
						if (bit_cnt == smb_pkg::ACK_SLOT) begin
							bit_cnt <= 4'h0;
							ack_request_flag <= 1'b0;
							sda_low <= 1'b0;
							if (is_addr && !master && !acked) begin
								ignore <= 1'b1;
								start_request <= 1'b0;
								phase <= smb_pkg::PH_SKIP;
							end else if (transmit_direction_flag || hw) begin
								si <= 1'b1;
								phase <= smb_pkg::PH_WAIT;
							end
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
							sda_low <= transmit_direction_flag && (bit_cnt != smb_pkg::LAST_BIT)
								&& !data[7];
						end
					end
				end
				// Waiting for software to clear the flag
				smb_pkg::PH_WAIT: begin
				end
				// Not addressed or done: stay off the wire until START or STOP
				smb_pkg::PH_SKIP: begin
				end
				default: phase <= smb_pkg::PH_IDLE;
			endcase
			// Choose the next frame once the byte is served
			if (do_next) begin
				bit_cnt <= 4'h0;
				is_addr <= 1'b0;
				dat_wr <= 1'b0;
				if (master && sto) begin
					phase <= smb_pkg::PH_STOP;
					step <= 2'h0;
				end else if (master && start_request) begin
					phase <= smb_pkg::PH_START;
					step <= 2'h0;
				end else if (!master && transmit_direction_flag && !far_ack) begin
					sda_low <= 1'b0;
					phase <= smb_pkg::PH_SKIP;
				end else begin
					// Loaded data transmits, else receive
					phase <= smb_pkg::PH_BYTE;
					transmit_direction_flag <= dat_wr;
					sda_low <= dat_wr && !data[7];
				end
			end
			// START seen on the wire; slave receive begins only when not the master
			if (start_det) begin
				bus_busy <= 1'b1;
				ignore <= 1'b0;
				if (!master && phase != smb_pkg::PH_START) begin
					// The fall that closes the START must not count as a bit
					bit_cnt <= smb_pkg::PRE_SLOT;
					transmit_direction_flag <= 1'b0;
					sda_low <= 1'b0;
					is_addr <= 1'b1;
					if (cfg[smb_pkg::CFG_EN] && !cfg[smb_pkg::CFG_INH])
						phase <= smb_pkg::PH_BYTE;
					else
						phase <= smb_pkg::PH_IDLE;
				end
			end
			// STOP ends any slave transfer
			if (stop_det) begin
				bus_busy <= 1'b0;
				if (!master) begin
					phase <= smb_pkg::PH_IDLE;
					transmit_direction_flag <= 1'b0;
					start_request <= 1'b0;
					sda_low <= 1'b0;
				end
			end
			// Disabled interface lets go of SDA and of its master clock pull; a raised flag still holds SCL
			if (!cfg[smb_pkg::CFG_EN]) begin
				phase <= smb_pkg::PH_IDLE;
				master <= 1'b0;
				mscl_low <= 1'b0;
				sda_low <= 1'b0;
			end
		end
	end

	// Checks on the engine
	AST_INHIBIT: assert property (@(posedge pclk) disable iff (!presetn)
		start_det && cfg[smb_pkg::CFG_INH] && !master
		|=> phase != smb_pkg::PH_BYTE)
		else $error("slave engine started while inhibited");
	AST_ADDR_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		phase == smb_pkg::PH_BYTE && rise_ev && is_addr && !hw &&
		bit_cnt == smb_pkg::LAST_BIT |=> si && ack_request_flag && start_request)
		else $error("address without ack request flag");
	AST_HW_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
		phase == smb_pkg::PH_BYTE && is_addr && hw && ack_out && !transmit_direction_flag &&
		bit_cnt == smb_pkg::ACK_SLOT && !scl_q2 && !fall_ev |=> sda_low)
		else $error("matching address not acked");
	AST_MUTED: assert property (@(posedge pclk) disable iff (!presetn)
		ignore && !master && !start_det |=> !$rose(si))
		else $error("slave flag raised after refused address");
	AST_RX_BEFORE: assert property (@(posedge pclk) disable iff (!presetn)
		phase == smb_pkg::PH_BYTE && rise_ev && !transmit_direction_flag && hw &&
		bit_cnt == smb_pkg::LAST_BIT |=> !si && !ack_request_flag)
		else $error("hardware ack flag posted before ack slot");
	AST_STOP_LEAVE: assert property (@(posedge pclk) disable iff (!presetn)
		stop_det && !master && cfg[smb_pkg::CFG_EN]
		|=> phase == smb_pkg::PH_IDLE && !transmit_direction_flag)
		else $error("slave mode kept after stop");
	AST_TX_AFTER: assert property (@(posedge pclk) disable iff (!presetn)
		phase == smb_pkg::PH_BYTE && transmit_direction_flag && !si &&
		bit_cnt == smb_pkg::LAST_BIT |=> !$rose(si) || arbitration_lost_flag)
		else $error("transmit flag before ack slot");
	AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		si && !scl_q2 |=> scl_drv [*2])
		else $error("clock released while flag set");
	AST_ACK_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
		phase == smb_pkg::PH_BYTE && !transmit_direction_flag && !hw && !fall_ev &&
		bit_cnt == smb_pkg::ACK_SLOT && !scl_q2 |=> sda_low == $past(ack))
		else $error("ack pin does not follow ack bit");
	AST_TO_RX: assert property (@(posedge pclk) disable iff (!presetn)
		do_next && !sto && !start_request && !dat_wr && !start_det && !stop_det &&
		cfg[smb_pkg::CFG_EN] && (master || !transmit_direction_flag || far_ack) |=> !transmit_direction_flag)
		else $error("no load but still transmitting");
endmodule : smb_ctrl

// >>> smb_pkg.sv
// Operation
// - Not inhibited: START plus address enters slave receive
// - No hardware ack: address raises flag, ack request
// - Hardware ack: matching address acked, flag after
// - Address NACKed: slave flags muted until START
// - No hardware ack: each received byte sets ack request
// - Hardware ack: preset ack bit sent automatically
// - STOP ends slave receive
// - Data write as slave receiver: become transmitter
// - Receive flag before ack, or after with hardware
// - Read address acked, loaded data is transmitted
// - No load after transmit flag: receive; STOP ends; after a NACK the slave goes to PH_SKIP instead
// - Slave transmit flag always after ack slot
// - Status nibble: master, transmit, start, stop
// - Status 1110: address loaded, sent, then 1100
// - 1100 with NACK: start restarts, stop aborts
// - 1100 with ACK: data, stop, start, or both
// - Flag cleared without data: master receiver 1000
// - 1000: send ack, then continue, stop or start
// - Ack bit one drives ACK, zero drives NACK
// - Hardware ack enable gives address recognition
package smb_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DATA = 8'h04;
	localparam logic [7:0] ADDR_SADDR = 8'h08;
	localparam logic [7:0] ADDR_SMASK = 8'h0C;
	localparam logic [7:0] ADDR_CFG = 8'h10;
	// Control and status bit positions
	localparam int CS_SI = 0;
	localparam int CS_ACK = 1;
	localparam int CS_ARB = 2;
	localparam int CS_ACK_REQUEST_FLAG = 3;
	localparam int CS_STO = 4;
	localparam int CS_STA = 5;
	// Configuration bit positions
	localparam int CFG_EN = 0;
	localparam int CFG_INH = 1;
	localparam int CFG_HWACK = 2;
	// Reset values
	localparam logic [7:0] SADDR_RST = 8'h00;
	localparam logic [7:0] SMASK_RST = 8'hFE;
	localparam logic [2:0] CFG_RST = 3'h0;
	// Bus timing: half of the generated clock period
	localparam int CLK_MHZ = 250;
	localparam int SCL_HALF_NS = 5000;
	localparam int SCL_HALF_CYC = SCL_HALF_NS * CLK_MHZ / 1000;
	// Bit slots within a byte frame
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// One below the first bit, so the START's own clock fall lands on zero
	localparam logic [3:0] PRE_SLOT = 4'hF;
	// Engine phases
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_START = 3'b001,
		PH_BYTE = 3'b010,
		PH_WAIT = 3'b011,
		PH_STOP = 3'b100,
		PH_SKIP = 3'b101
	} phase_e;
endpackage : smb_pkg

// >>> smb_remote.sv
`timescale 1ns/1ps
module smb_remote (
	// Link clock
	input wire logic lclk,
	// Wire levels seen on the bus
	input wire logic scl,
	input wire logic sda,
	// Our pulls, high means released
	output logic m_scl,
	output logic m_sda
);
	// Bus idles released; our clock stands still outside frames
	initial begin
		m_scl = 1'b1;
		m_sda = 1'b1;
	end
	// Release SCL and wait out any stretching by the slave
	task automatic hi;
		m_scl <= 1'b1;
		@(posedge lclk);
		while (scl !== 1'b1) begin
			@(posedge lclk);
		end
	endtask : hi
	// Data set while SCL is low, sampled while it is high
	task automatic bit_io(input logic v, output logic r);
		m_sda <= v;
		@(posedge lclk);
		hi();
		r = sda;
		@(posedge lclk);
		m_scl <= 1'b0;
		@(posedge lclk);
	endtask : bit_io
	// START: SDA falls while SCL is high
	task automatic start;
		m_sda <= 1'b1;
		hi();
		m_sda <= 1'b0;
		@(posedge lclk);
		m_scl <= 1'b0;
		@(posedge lclk);
	endtask : start
	// STOP: SDA rises while SCL is high
	task automatic stop;
		m_sda <= 1'b0;
		@(posedge lclk);
		hi();
		m_sda <= 1'b1;
		@(posedge lclk);
	endtask : stop
	// Byte out MSB first, then the slave's answer (0 is ACK)
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, ack);
	endtask : wbyte
	// Byte in MSB first, then our answer nk (0 is ACK)
	task automatic rbyte(input logic nk, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nk, r);
	endtask : rbyte
endmodule : smb_remote

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(n, x, s) begin \
	checked++; \
	if ((s) !== (x)) begin \
		failures++; \
		$display("ERROR %s exp %h got %h", n, x, s); \
	end \
end
module tb_top;
	// Clocks, reset and APB master side
	logic pclk = 1'b0;
	logic lclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	// Pins; each wire is pulled up and low wins
	logic scl_out, scl_oe_n, sda_out, sda_oe_n, m_scl, m_sda;
	wire scl = m_scl & (scl_oe_n | scl_out);
	wire sda = m_sda & (sda_oe_n | sda_out);
	// Counters and last results
	int failures = 0;
	int checked = 0;
	logic [31:0] q;
	logic e, a;
	logic [7:0] b;
	always #2 pclk = ~pclk;
	always #32 lclk = ~lclk;
	smb_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
		.scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n));
	smb_remote rm (.lclk(lclk), .scl(scl), .sda(sda), .m_scl(m_scl),
		.m_sda(m_sda));
	// One APB transfer; an idle cycle after it avoids double drives
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Poll the control word until the flag rises, bounded
	task automatic wait_si;
		int n;
		n = 0;
		q = 32'h0;
		while (q[0] !== 1'b1 && n < 20000) begin
			apb(1'b0, smb_pkg::ADDR_CTRL, 32'h0);
			n++;
		end
		`CHK("si", 1'b1, q[0])
	endtask : wait_si
	// Give the stretch time to settle, then look at SCL
	task automatic held;
		repeat (40) @(posedge pclk);
		`CHK("scl held", 1'b0, scl)
	endtask : held
	task automatic finish_test;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	// Watchdog: the tests need well under this span
	initial begin
		#400000;
		failures++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, unmapped place, read back
		apb(1'b0, smb_pkg::ADDR_SMASK, 32'h0);
		`CHK("smask", smb_pkg::SMASK_RST, q[7:0])
		apb(1'b0, 8'h14, 32'h0);
		`CHK("unmapped", 1'b1, e)
		`CHK("pready", 1'b1, pready)
		apb(1'b1, smb_pkg::ADDR_SADDR, 32'h5A);
		apb(1'b0, smb_pkg::ADDR_SADDR, 32'h0);
		`CHK("saddr", 8'h5A, q[7:0])
		$display("test regs done");
		// Slave write acked by software
		apb(1'b1, smb_pkg::ADDR_CFG, 32'h1);
		fork
			begin
				rm.start();
				rm.wbyte(8'h5A, a);
				`CHK("addr ack", 1'b0, a)
				rm.wbyte(8'hA5, a);
				`CHK("data nack", 1'b1, a)
			end
			begin
				wait_si();
				`CHK("status", 4'h2, q[7:4])
				`CHK("ack_request_flag", 1'b1, q[3])
				held();
				apb(1'b1, smb_pkg::ADDR_CTRL, 32'h02);
				wait_si();
				`CHK("ack_request_flag", 1'b1, q[3])
				held(); // Flag stands before the ack slot
				// Data read only while the flag is up
				apb(1'b0, smb_pkg::ADDR_DATA, 32'h0);
				`CHK("rx", 8'hA5, q[7:0])
				apb(1'b1, smb_pkg::ADDR_CTRL, 32'h00);
			end
		join
		rm.stop();
		apb(1'b0, smb_pkg::ADDR_CTRL, 32'h0);
		`CHK("idle", 4'h0, q[7:4])
		$display("test sw ack done");
		// Inhibited slave ignores its address
		apb(1'b1, smb_pkg::ADDR_CFG, 32'h3);
		rm.start();
		rm.wbyte(8'h5A, a);
		`CHK("inh nack", 1'b1, a)
		rm.stop();
		apb(1'b0, smb_pkg::ADDR_CTRL, 32'h0);
		`CHK("inh si", 1'b0, q[0])
		$display("test inhibit done");
		// Hardware ack: address matched, data answered from preset
		apb(1'b1, smb_pkg::ADDR_CFG, 32'h5);
		apb(1'b1, smb_pkg::ADDR_CTRL, 32'h02);
		fork
			begin
				rm.start();
				rm.wbyte(8'h5A, a);
				`CHK("hw addr", 1'b0, a)
				rm.wbyte(8'h3C, a);
				`CHK("hw nack", 1'b1, a)
			end
			begin
				wait_si();
				`CHK("hw ack_request_flag", 1'b0, q[3])
				apb(1'b1, smb_pkg::ADDR_CTRL, 32'h00);
				wait_si();
				apb(1'b1, smb_pkg::ADDR_CTRL, 32'h00);
			end
		join
		rm.stop();
		// Unmatched address: muted until the next START
		rm.start();
		rm.wbyte(8'h22, a);
		`CHK("mis nack", 1'b1, a)
		rm.wbyte(8'h5A, a);
		`CHK("muted", 1'b1, a)
		rm.stop();
		apb(1'b0, smb_pkg::ADDR_CTRL, 32'h0);
		`CHK("mute si", 1'b0, q[0])
		$display("test hw ack done");
		// Slave read: two bytes, master NACKs the last
		fork
			begin
				rm.start();
				rm.wbyte(8'h5B, a);
				rm.rbyte(1'b0, b);
				`CHK("tx1", 8'hC3, b)
				rm.rbyte(1'b1, b);
				`CHK("tx2", 8'h81, b)
			end
			begin
				wait_si();
				apb(1'b1, smb_pkg::ADDR_DATA, 32'hC3);
				apb(1'b1, smb_pkg::ADDR_CTRL, 32'h00);
				wait_si();
				`CHK("tx status", 4'h4, q[7:4])
				`CHK("ack seen", 1'b1, q[1])
				apb(1'b1, smb_pkg::ADDR_DATA, 32'h81);
				apb(1'b1, smb_pkg::ADDR_CTRL, 32'h00);
				wait_si();
				`CHK("nack seen", 1'b0, q[1])
				// Nothing loaded after the NACK
				apb(1'b1, smb_pkg::ADDR_CTRL, 32'h00);
			end
		join
		rm.stop();
		apb(1'b0, smb_pkg::ADDR_CTRL, 32'h0);
		`CHK("tx end", 4'h0, q[7:4])
		$display("test slave read done");
		// Master: START, unanswered address, abort by STOP
		apb(1'b1, smb_pkg::ADDR_CTRL, 32'h20);
		wait_si();
		`CHK("m start", 4'hE, q[7:4])
		apb(1'b1, smb_pkg::ADDR_DATA, 32'hA0);
		apb(1'b1, smb_pkg::ADDR_CTRL, 32'h00);
		wait_si();
		`CHK("m addr", 4'hC, q[7:4])
		`CHK("m nacked", 1'b0, q[1])
		apb(1'b1, smb_pkg::ADDR_CTRL, 32'h10);
		repeat (6 * smb_pkg::SCL_HALF_CYC) @(posedge pclk);
		apb(1'b0, smb_pkg::ADDR_CTRL, 32'h0);
		`CHK("m stop", 4'h0, q[7:4])
		`CHK("sda idle", 1'b1, sda)
		$display("test master done");
		finish_test();
	end
endmodule : tb_top
